// [iesw_irq_cell.sv]
// one sticky interrupt flag gated by its enable
`timescale 1ns/100ps
`default_nettype none
module iesw_irq_cell
  import iesw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic event_pulse,
  input wire logic clear,
  output logic flag_d,
  output logic flag_q,
  output logic irq
);

  // set wins over a write-one clear in the same cycle
  always_comb begin
    flag_d = (event_pulse & enable) | (flag_q & ~clear);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // a cleared enable silences the source even with a stale flag
  assign irq = flag_q & enable;

endmodule
`default_nettype wire

// [iesw_pkg.sv]
// shared constants and types for the interrupt-enable and square-wave select block
package iesw_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IESW_IDX_STATUS = 8'h0f;
  localparam logic [7:0] IESW_IDX_ENABLE = 8'h12;
  localparam logic [7:0] IESW_IDX_WAVE = 8'h13;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int IESW_BIT_BATT = 4;
  localparam int IESW_BIT_TIMER = 3;
  localparam int IESW_BIT_ALARM = 2;
  localparam int IESW_BIT_EXT = 1;
  localparam int IESW_BIT_UNUSED = 0;
  localparam int IESW_BIT_WAVE_EN = 7;
  localparam int IESW_SEL_MSB = 4;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [7:0] IESW_WAVE_RST = 8'h26;
  localparam logic [4:0] IESW_ENABLE_RST = 5'h00;

  // ------------------------------------------------------------
  // wave select codes
  // ------------------------------------------------------------
  localparam logic [4:0] IESW_SEL_CENTURY = 5'h00;
  localparam logic [4:0] IESW_SEL_32K = 5'h01;
  localparam logic [4:0] IESW_SEL_512 = 5'h06;
  localparam logic [4:0] IESW_SEL_128 = 5'h08;
  localparam logic [4:0] IESW_SEL_LAST_DIV = 5'h14;
  localparam logic [4:0] IESW_SEL_MINUTE = 5'h15;
  localparam logic [4:0] IESW_SEL_16K = 5'h16;
  localparam logic [4:0] IESW_SEL_100HZ = 5'h17;
  localparam logic [4:0] IESW_SEL_HOUR = 5'h18;
  localparam logic [4:0] IESW_SEL_DAY = 5'h19;
  localparam logic [4:0] IESW_SEL_TIMER_IRQ = 5'h1a;
  localparam logic [4:0] IESW_SEL_TIMER_IRQ_N = 5'h1b;
  localparam logic [4:0] IESW_SEL_YEAR = 5'h1c;
  localparam logic [4:0] IESW_SEL_CNT_1HZ = 5'h1d;
  localparam logic [4:0] IESW_SEL_AC_32S = 5'h1e;
  localparam logic [4:0] IESW_SEL_AC_8S = 5'h1f;

  // ------------------------------------------------------------
  // divider counts
  // ------------------------------------------------------------
  localparam int IESW_DIV_W = 21;
  localparam logic [8:0] IESW_RC122_HALF = 9'h10c;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic battery_low;
    logic timer_zero;
    logic alarm_match;
    logic ext_edge;
  } iesw_evt_t;

  typedef struct packed {
    logic century;
    logic minute;
    logic hz100;
    logic hour;
    logic day;
    logic year;
    logic hz1_counters;
    logic autocal_32s;
    logic autocal_8s;
  } iesw_pulse_t;

endpackage

// [iesw_tb_top.sv]
// self-checking testbench for the interrupt enable and square-wave select block
`timescale 1ns/100ps
`default_nettype none
module iesw_tb_top;
  import iesw_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam logic [31:0] A_STAT = {22'h0, IESW_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_EN = {22'h0, IESW_IDX_ENABLE, 2'b00};
  localparam logic [31:0] A_WAVE = {22'h0, IESW_IDX_WAVE, 2'b00};
  localparam logic [4:0] PCODE [9] = '{IESW_SEL_CENTURY, IESW_SEL_MINUTE, IESW_SEL_100HZ, IESW_SEL_HOUR,
    IESW_SEL_DAY, IESW_SEL_YEAR, IESW_SEL_CNT_1HZ, IESW_SEL_AC_32S, IESW_SEL_AC_8S};
  logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, osc_edge, rc_osc_sel, clk_lvl, sw_lvl;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  iesw_evt_t evt;
  iesw_pulse_t pulses;
  logic battery_low_irq, timer_irq, alarm_irq, ext_irq, timer_flag, irq;
  logic square_wave_out, wave_output_enable, clk_pin_out, switch_pin_out;
  logic [3:0] irq_vec;
  int err_total, total_checks, n, m;

  assign hready = hreadyout;
  assign irq_vec = {battery_low_irq, timer_irq, alarm_irq, ext_irq};

  iesw_top iesw_top_i (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .evt(evt), .pulses(pulses), .osc_edge(osc_edge), .rc_osc_sel(rc_osc_sel),
    .clk_pin_static_level(clk_lvl), .switch_pin_static_level(sw_lvl), .battery_low_irq(battery_low_irq),
    .timer_irq(timer_irq), .alarm_irq(alarm_irq), .ext_irq(ext_irq), .timer_flag(timer_flag), .irq(irq),
    .square_wave_out(square_wave_out), .wave_output_enable(wave_output_enable), .clk_pin_out(clk_pin_out),
    .switch_pin_out(switch_pin_out));

  always #2 clock = ~clock;
  // one oscillator half-period pulse every other cycle, free running
  always @(posedge clock) osc_edge <= ~osc_edge;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int exp_half(input logic [4:0] code, input logic rc);
    if (code == 5'h08 && rc) return 268;
    if (code == 5'h01) return 1;
    return 1 << code;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus_op(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk("hresp", hresp, 0);
  endtask

  task automatic evt_pulse(input int i);
    @(posedge clock);
    evt <= iesw_evt_t'(4'h1 << i);
    @(posedge clock);
    evt <= '0;
    @(posedge clock);
    #1;
  endtask

  // counts toggles of the clock pin (n) and raw wave (m), or the pin's high cycles when highs is set
  task automatic count_pin(input int cyc, input bit highs);
    logic prev, prev_raw;
    n = 0;
    m = 0;
    prev = 1'b0;
    prev_raw = 1'b0;
    // sampled at the falling edge, away from the edge that launches the wave
    if (!highs) begin
      @(negedge clock);
      prev = clk_pin_out;
      prev_raw = square_wave_out;
    end
    repeat (cyc) begin
      @(negedge clock);
      if (highs) n += (clk_pin_out === 1'b1);
      else n += (clk_pin_out !== prev);
      m += (square_wave_out !== prev_raw);
      prev = clk_pin_out;
      prev_raw = square_wave_out;
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    close_out();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    evt = '0;
    pulses = '0;
    osc_edge = 1'b0;
    rc_osc_sel = 1'b0;
    clk_lvl = 1'b1;
    sw_lvl = 1'b0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'he1fd));
    repeat (8) @(posedge clock);
    #1;
    chk("clk_pin_rst", clk_pin_out, clk_lvl);
    chk("sw_pin_rst", switch_pin_out, sw_lvl);
    chk("irq_rst", irq, 0);
    @(posedge clock);
    sys_rst <= 1'b0;
    bus_op(1'b0, A_WAVE, 0);
    chk("wave_rst", rd, 32'h26);
    bus_op(1'b0, A_EN, 0);
    chk("en_rst", rd, 32'h0);
    bus_op(1'b1, 32'h0, 32'hff);
    bus_op(1'b0, 32'h0, 0);
    chk("unmapped", rd, 32'h0);
    bus_op(1'b0, A_WAVE, 0);
    chk("wave_kept", rd, 32'h26);
    hwdata <= $urandom;
    v = $urandom & 32'hffff_fffe;
    bus_op(1'b1, A_EN, v);
    bus_op(1'b0, A_EN, 0);
    chk("en_rw", rd, {27'h0000000, v[4:0]});
    bus_op(1'b1, A_WAVE, 32'h7f);
    bus_op(1'b0, A_WAVE, 0);
    chk("wave_rw", rd, 32'h7f);
    chk("wave_en_bit", wave_output_enable, 0);
    $display("test registers done");

    for (int i = 0; i < 4; i++) begin
      bus_op(1'b1, A_EN, 0);
      evt_pulse(i);
      chk("src_off", irq_vec[i], 0);
      bus_op(1'b0, A_STAT, 0);
      chk("stat_off", rd, 0);
      bus_op(1'b1, A_EN, 32'h1 << (i + 1));
      evt_pulse(i);
      chk("src_on", irq_vec[i], 1);
      chk("irq_on", irq, 1);
      chk("timer_flag", timer_flag, i == 2);
      bus_op(1'b0, A_STAT, 0);
      chk("stat_on", rd, 32'h1 << (i + 1));
      bus_op(1'b1, A_EN, 0);
      #1;
      chk("src_masked", irq_vec[i], 0);
      chk("irq_masked", irq, 0);
      bus_op(1'b1, A_STAT, 32'h1 << (i + 1));
      bus_op(1'b0, A_STAT, 0);
      chk("stat_clr", rd, 0);
    end
    // external event and its write-one clear land on the same edge
    bus_op(1'b1, A_EN, 32'h2);
    fork
      bus_op(1'b1, A_STAT, 32'h2);
      begin
        repeat (2) @(posedge clock);
        evt <= iesw_evt_t'(4'h1);
        @(posedge clock);
        evt <= '0;
      end
    join
    #1;
    chk("set_beats_clr", ext_irq, 1);
    bus_op(1'b1, A_STAT, 32'h2);
    bus_op(1'b1, A_EN, 0);
    bus_op(1'b0, A_STAT, 0);
    chk("stat_final", rd, 0);
    $display("test interrupts done");

    bus_op(1'b1, A_WAVE, 32'h80 | IESW_SEL_16K);
    repeat (4) @(posedge clock);
    count_pin(2048, 1'b0);
    chk("wave_16k", n, 512);

    for (int c = 1; c <= 8; c++) begin
      bus_op(1'b1, A_WAVE, 32'h80 | c);
      repeat (4) @(posedge clock);
      count_pin(2048, 1'b0);
      chk("wave_toggles", n, 1024 / exp_half(c[4:0], 1'b0));
    end
    chk("wave_en_on", wave_output_enable, 1);
    rc_osc_sel <= 1'b1;
    repeat (4) @(posedge clock);
    count_pin(4288, 1'b0);
    chk("rc_toggles", n, 2144 / exp_half(5'h08, 1'b1));
    rc_osc_sel <= 1'b0;
    clk_lvl <= 1'($urandom);
    sw_lvl <= 1'($urandom);
    bus_op(1'b1, A_WAVE, 32'h06);
    repeat (4) @(posedge clock);
    count_pin(512, 1'b0);
    chk("wave_off", n, 0);
    chk("raw_wave", m, 4);
    chk("clk_pin_off", clk_pin_out, clk_lvl);
    chk("sw_pin_off", switch_pin_out, sw_lvl);
    $display("test square wave done");

    for (int k = 0; k < 9; k++) begin
      bus_op(1'b1, A_WAVE, 32'h80 | PCODE[k]);
      repeat (4) @(posedge clock);
      pulses <= iesw_pulse_t'(9'h100 >> k);
      @(posedge clock);
      pulses <= '0;
      count_pin(8, 1'b1);
      chk("pulse_highs", n, 1);
    end
    bus_op(1'b1, A_WAVE, 32'h80 | IESW_SEL_TIMER_IRQ);
    repeat (2) @(posedge clock);
    count_pin(8, 1'b1);
    chk("timer_irq_pin", n, 0);
    bus_op(1'b1, A_WAVE, 32'h80 | IESW_SEL_TIMER_IRQ_N);
    repeat (2) @(posedge clock);
    count_pin(8, 1'b1);
    chk("timer_irq_n_pin", n, 8);
    $display("test pulses done");
    close_out();
  end

endmodule
`default_nettype wire

// [iesw_top.sv]
// interrupt enable and square-wave control registers behind an ahb-lite slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module iesw_top
  import iesw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire iesw_evt_t evt,
  input wire iesw_pulse_t pulses,
  input wire logic osc_edge,
  input wire logic rc_osc_sel,
  input wire logic clk_pin_static_level,
  input wire logic switch_pin_static_level,
  output logic battery_low_irq,
  output logic timer_irq,
  output logic alarm_irq,
  output logic ext_irq,
  output logic timer_flag,
  output logic irq,
  output logic square_wave_out,
  output logic wave_output_enable,
  output logic clk_pin_out,
  output logic switch_pin_out
);

  // ------------------------------------------------------------
  // bus slave state
  // ------------------------------------------------------------
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0] en_q, en_d;
  logic [7:0] wave_q, wave_d;
  logic [4:1] flag_d, flag_q, src_irq, evt_vec, clr_vec;
  logic addr_ok, wr_en, wr_status;
  logic [7:0] addr_idx;

  // only word transfers are issued, so hsize is not decoded
  assign addr_ok = hsel & htrans[1] & hready;
  assign addr_idx = haddr[9:2];
  assign wr_en = wr_pend_q;
  assign wr_status = wr_en & (wr_idx_q == IESW_IDX_STATUS);
  assign evt_vec = {evt.battery_low, evt.timer_zero, evt.alarm_match, evt.ext_edge};
  assign clr_vec = wr_status ? hwdata[4:1] : 4'h0;

  always_comb begin
    wr_pend_d = addr_ok & hwrite;
    wr_idx_d = addr_ok ? addr_idx : wr_idx_q;
    en_d = en_q;
    wave_d = wave_q;
    // bit 0 is stored as written; keeping it zero is up to software
    if (wr_en && (wr_idx_q == IESW_IDX_ENABLE)) begin
      en_d = hwdata[4:0];
    end
    if (wr_en && (wr_idx_q == IESW_IDX_WAVE)) begin
      wave_d = hwdata[7:0];
    end
  end

  // read data is taken from next values so a read right behind a write sees it
  always_comb begin
    rdata_d = rdata_q;
    if (addr_ok && !hwrite) begin
      case (addr_idx)
        IESW_IDX_STATUS: rdata_d = {27'h0000000, flag_d, 1'b0};
        IESW_IDX_ENABLE: rdata_d = {27'h0000000, en_d};
        IESW_IDX_WAVE: rdata_d = {24'h000000, wave_d};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      rdata_q <= 32'h00000000;
      en_q <= IESW_ENABLE_RST;
      wave_q <= IESW_WAVE_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      rdata_q <= rdata_d;
      en_q <= en_d;
      wave_q <= wave_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ------------------------------------------------------------
  // interrupt sources
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi <= 4; gi++) begin : g_src
      iesw_irq_cell u_cell (
        .clock(clock),
        .sys_rst(sys_rst),
        .enable(en_q[gi]),
        .event_pulse(evt_vec[gi]),
        .clear(clr_vec[gi]),
        .flag_d(flag_d[gi]),
        .flag_q(flag_q[gi]),
        .irq(src_irq[gi])
      );
    end
  endgenerate

  assign battery_low_irq = src_irq[IESW_BIT_BATT];
  assign timer_irq = src_irq[IESW_BIT_TIMER];
  assign alarm_irq = src_irq[IESW_BIT_ALARM];
  assign ext_irq = src_irq[IESW_BIT_EXT];
  assign timer_flag = flag_q[IESW_BIT_TIMER];
  assign irq = |src_irq;

  // ------------------------------------------------------------
  // square wave and pins
  // ------------------------------------------------------------
  iesw_wave_gen u_wave (
    .clock(clock),
    .sys_rst(sys_rst),
    .osc_edge(osc_edge),
    .rc_osc_sel(rc_osc_sel),
    .wave_sel(wave_q[IESW_SEL_MSB:0]),
    .pulses(pulses),
    .timer_irq(timer_irq),
    .wave_q(square_wave_out)
  );

  assign wave_output_enable = wave_q[IESW_BIT_WAVE_EN];
  assign clk_pin_out = wave_output_enable ? square_wave_out : clk_pin_static_level;
  assign switch_pin_out = wave_output_enable ? square_wave_out : switch_pin_static_level;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // a write that clears the enable in the same cycle may drop the interrupt, never the flag
  a_timer_flag_set: assert property (evt.timer_zero && en_q[IESW_BIT_TIMER] |=>
    timer_flag && (timer_irq == en_q[IESW_BIT_TIMER]))
    else $error("timer zero with enable did not set flag and interrupt");
  a_timer_disabled: assert property (!en_q[IESW_BIT_TIMER] |-> !timer_irq)
    else $error("timer interrupt while disabled");
  a_sel_after_rst: assert property ($past(sys_rst) |-> wave_q == IESW_WAVE_RST)
    else $error("wave register not at reset value");
  a_sel_write: assert property (wr_en && (wr_idx_q == IESW_IDX_WAVE) |=> wave_q == $past(hwdata[7:0]))
    else $error("wave register write lost");
  a_pin_static: assert property (!wave_output_enable |-> clk_pin_out == clk_pin_static_level)
    else $error("clock pin not at static level");
  a_pin_wave: assert property (wave_output_enable |-> switch_pin_out == square_wave_out)
    else $error("switch pin not carrying square wave");
  a_gate_off: assert property (!en_q[IESW_BIT_BATT] |-> !battery_low_irq)
    else $error("battery interrupt while disabled");
  a_alarm_raise: assert property (evt.alarm_match && en_q[IESW_BIT_ALARM] |=>
    flag_q[IESW_BIT_ALARM] && (alarm_irq == en_q[IESW_BIT_ALARM]) && (irq || !en_q[IESW_BIT_ALARM]))
    else $error("alarm event did not raise interrupt");
  a_set_beats_clr: assert property (evt.ext_edge && en_q[IESW_BIT_EXT] && clr_vec[IESW_BIT_EXT] |=>
    flag_q[IESW_BIT_EXT])
    else $error("clear won over a simultaneous external event");

  // ------------------------------------------------------------
  // flag set, clear and register checks
  // ------------------------------------------------------------
  a_timer_no_set: assert property (!en_q[IESW_BIT_TIMER] && !timer_flag |=> !timer_flag && !timer_irq)
    else $error("disabled timer event set the flag");
  a_timer_clear: assert property (wr_status && hwdata[IESW_BIT_TIMER] && !evt.timer_zero |=> !timer_flag)
    else $error("write one did not clear the timer flag");
  a_batt_raise: assert property (evt.battery_low && en_q[IESW_BIT_BATT] |=> flag_q[IESW_BIT_BATT])
    else $error("battery event did not set its flag");
  a_batt_no_set: assert property (!en_q[IESW_BIT_BATT] && !flag_q[IESW_BIT_BATT] |=>
    !flag_q[IESW_BIT_BATT] && !battery_low_irq)
    else $error("disabled battery event set the flag");
  a_ext_raise: assert property (evt.ext_edge && en_q[IESW_BIT_EXT] |=> flag_q[IESW_BIT_EXT])
    else $error("external event did not set its flag");
  a_en_write: assert property (wr_en && (wr_idx_q == IESW_IDX_ENABLE) |=> en_q == $past(hwdata[4:0]))
    else $error("enable register write lost");
  a_rd_wave: assert property (addr_ok && !hwrite && (addr_idx == IESW_IDX_WAVE) |=>
    hrdata == {24'h000000, wave_q})
    else $error("wave register read data wrong");

  c_timer_irq: cover property (evt.timer_zero && en_q[IESW_BIT_TIMER] ##1 timer_irq);
  c_wave_on: cover property ($rose(wave_output_enable));
  c_status_clear: cover property (timer_flag ##1 wr_status ##1 !timer_flag);
  c_set_clr: cover property (evt.ext_edge && en_q[IESW_BIT_EXT] && clr_vec[IESW_BIT_EXT]);

endmodule
`default_nettype wire

// [iesw_wave_gen.sv]
// square wave and test pulse generator driven by the wave select code
`timescale 1ns/100ps
`default_nettype none
module iesw_wave_gen
  import iesw_pkg::*;
#(
  parameter int DIV_W = IESW_DIV_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic osc_edge,
  input wire logic rc_osc_sel,
  input wire logic [4:0] wave_sel,
  input wire iesw_pulse_t pulses,
  input wire logic timer_irq,
  output logic wave_q
);

  logic [DIV_W-1:0] div_q, div_d;
  logic [8:0] rc_cnt_q, rc_cnt_d;
  logic rc_wave_q, rc_wave_d;
  logic wave_d;

  // osc_edge comes at twice 32.768 kHz, so div bit n is 32.768 kHz / 2^n
  always_comb begin
    div_d = div_q;
    rc_cnt_d = rc_cnt_q;
    rc_wave_d = rc_wave_q;
    if (osc_edge) begin
      div_d = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      if (rc_cnt_q == IESW_RC122_HALF - 9'h001) begin
        rc_cnt_d = 9'h000;
        rc_wave_d = ~rc_wave_q;
      end else begin
        rc_cnt_d = rc_cnt_q + 9'h001;
      end
    end
  end

  always_comb begin
    case (wave_sel)
      IESW_SEL_CENTURY: wave_d = pulses.century;
      IESW_SEL_32K: wave_d = div_q[0];
      IESW_SEL_128: wave_d = rc_osc_sel ? rc_wave_q : div_q[8];
      IESW_SEL_MINUTE: wave_d = pulses.minute;
      IESW_SEL_16K: wave_d = div_q[1];
      IESW_SEL_100HZ: wave_d = pulses.hz100;
      IESW_SEL_HOUR: wave_d = pulses.hour;
      IESW_SEL_DAY: wave_d = pulses.day;
      IESW_SEL_TIMER_IRQ: wave_d = timer_irq;
      IESW_SEL_TIMER_IRQ_N: wave_d = ~timer_irq;
      IESW_SEL_YEAR: wave_d = pulses.year;
      IESW_SEL_CNT_1HZ: wave_d = pulses.hz1_counters;
      IESW_SEL_AC_32S: wave_d = pulses.autocal_32s;
      IESW_SEL_AC_8S: wave_d = pulses.autocal_8s;
      default: wave_d = (wave_sel <= IESW_SEL_LAST_DIV) ? div_q[wave_sel] : 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_q <= '0;
      rc_cnt_q <= 9'h000;
      rc_wave_q <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      div_q <= div_d;
      rc_cnt_q <= rc_cnt_d;
      rc_wave_q <= rc_wave_d;
      wave_q <= wave_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_xt_128_tap: assert property (@(posedge clock) disable iff (sys_rst)
    ($past(wave_sel) == IESW_SEL_128) && !$past(rc_osc_sel) |-> wave_q == $past(div_q[8]))
    else $error("128 Hz select does not follow divider bit 8");
  a_512_tap: assert property (@(posedge clock) disable iff (sys_rst)
    ($past(wave_sel) == IESW_SEL_512) |-> wave_q == $past(div_q[6]))
    else $error("512 Hz select does not follow divider bit 6");
  a_century_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    ($past(wave_sel) == IESW_SEL_CENTURY) |-> wave_q == $past(pulses.century))
    else $error("century select does not pass the century pulse");
  a_rc_toggle_gap: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(rc_wave_q) |-> $past(osc_edge) && ($past(rc_cnt_q) == IESW_RC122_HALF - 9'h001))
    else $error("rc wave toggled off its divide count");
  c_rc_122: cover property (@(posedge clock) disable iff (sys_rst)
    (wave_sel == IESW_SEL_128) && rc_osc_sel && $changed(rc_wave_q));

endmodule
`default_nettype wire
